//--- cgs_pkg.sv
// Package for the chopper gate sequencer: constants, state and carriers.
// Assumes a 100 MHz system clock; all values are shared by the top module.
package cgs_pkg;

   // Clock and phase-locked tick generation
   localparam int          CGS_CLK_NS      = 10;
   localparam int          CGS_PLL_MULT    = 10;
   localparam int          CGS_PER_W       = 24;
   localparam logic [3:0]  CGS_PHASE_LAST  = 4'h9;

   // Centre windows within the ten ticks of one segment period
   localparam logic [3:0]  CGS_HI_FIRST    = 4'h1;
   localparam logic [3:0]  CGS_HI_LAST     = 4'h3;
   localparam logic [3:0]  CGS_LO_FIRST    = 4'h6;
   localparam logic [3:0]  CGS_LO_LAST     = 4'h8;

   // Indicator dividers, in input edges per indicator toggle
   localparam int          CGS_LED_W       = 8;
   localparam int          CGS_HALF_LED_DIV = 15;
   localparam int          CGS_SEG_LED_DIV  = 50;

   // Simulated detector waveform half period
   localparam int          CGS_TEST_HALF_US  = 1000;
   localparam int          CGS_TEST_HALF_CYC =
      (CGS_TEST_HALF_US * 1000) / CGS_CLK_NS;
   localparam int          CGS_TEST_W      = 24;

   // Reset values
   localparam logic [3:0]  CGS_SYNC_RST    = 4'h0;
   localparam logic [3:0]  CGS_PHASE_RST   = 4'h0;

   typedef enum logic [1:0] {
      CGS_ACQ  = 2'b01,
      CGS_LOCK = 2'b10
   } cgs_pll_state_t;

   typedef struct packed {
      logic meas;
      logic measDark;
      logic reference;
      logic refDark;
   } cgs_gates_t;

   typedef struct packed {
      logic darkSwitchOpen;
      logic testGenEn;
      logic testWave;
   } cgs_switch_t;

   localparam cgs_gates_t  CGS_GATES_RST  = '{1'b0, 1'b0, 1'b0, 1'b0};
   localparam cgs_switch_t CGS_SWITCH_RST = '{1'b0, 1'b0, 1'b0};

endpackage

//--- cgs_chopper_gate_seq.sv
// Chopper gate sequencer: four sample-and-hold gates, indicators, switches.
// Assumes wheel sensor and request pins are asynchronous to clk.
`timescale 1ns/1ps
module cgs_chopper_gate_seq
   import cgs_pkg::*;
#(
   parameter int TEST_HALF_CYC = CGS_TEST_HALF_CYC,
   parameter int HALF_LED_DIV  = CGS_HALF_LED_DIV,
   parameter int SEG_LED_DIV   = CGS_SEG_LED_DIV
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Wheel sensors, high wheel half is the measurement half
   input  wire logic        wheelHalfPin,
   input  wire logic        segmentPin,
   // Operator requests
   input  wire logic        darkCalReq,
   input  wire logic        elecTestReq,
   // Sample-and-hold gates
   output cgs_gates_t       gates,
   // Detector path switches and test generator
   output cgs_switch_t      switches,
   // Indicators and lock status
   output logic             wheelHalfLed,
   output logic             segmentLed,
   output logic             pllLocked
);

   function automatic logic [CGS_LED_W-1:0] ledNext(
      input logic [CGS_LED_W-1:0] cnt,
      input int                   div
   );
      ledNext = (cnt >= CGS_LED_W'(div - 1)) ? '0 : cnt + 1'b1;
   endfunction

   logic [3:0]              sync1Q;
   logic [3:0]              sync2Q;
   logic                    segPrevQ;
   logic                    halfPrevQ;
   logic [CGS_PER_W-1:0]    periodCntQ;
   logic [CGS_PER_W-1:0]    periodQ;
   logic [CGS_PER_W-1:0]    tickCntQ;
   logic [3:0]              phaseQ;
   logic                    riseSeenQ;
   cgs_pll_state_t          stateQ;
   cgs_pll_state_t          stateD;
   logic [CGS_LED_W-1:0]    halfLedCntQ;
   logic [CGS_LED_W-1:0]    segLedCntQ;
   logic [CGS_TEST_W-1:0]   testCntQ;
   cgs_gates_t              gatesD;
   cgs_switch_t             switchD;

   wire logic               wheelS    = sync2Q[0];
   wire logic               segS      = sync2Q[1];
   wire logic               darkCalS  = sync2Q[2];
   wire logic               elecTestS = sync2Q[3];
   wire logic               segRise   = segS & ~segPrevQ;
   wire logic               halfEdge  = wheelS ^ halfPrevQ;
   wire logic               perOvf    = &periodCntQ;
   wire logic [CGS_PER_W-1:0] tickLenRaw =
      periodQ / CGS_PER_W'(CGS_PLL_MULT);
   wire logic [CGS_PER_W-1:0] tickLen =
      (tickLenRaw == '0) ? CGS_PER_W'(1) : tickLenRaw;
   wire logic               tick      = (tickCntQ >= tickLen - 1'b1);
   wire logic               locked    = (stateQ == CGS_LOCK);
   wire logic               inHi      = (phaseQ >= CGS_HI_FIRST) &
                                        (phaseQ <= CGS_HI_LAST);
   wire logic               inLo      = (phaseQ >= CGS_LO_FIRST) &
                                        (phaseQ <= CGS_LO_LAST);
   wire logic               testWrap  =
      (testCntQ >= CGS_TEST_W'(TEST_HALF_CYC - 1));

   // Two-stage synchronisers on all asynchronous inputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1Q <= CGS_SYNC_RST;
         sync2Q <= CGS_SYNC_RST;
      end else begin
         sync1Q <= {elecTestReq, darkCalReq, segmentPin, wheelHalfPin};
         sync2Q <= sync1Q;
      end
   end

   // Segment period measurement, the reference for the tick multiplier
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         segPrevQ   <= 1'b0;
         halfPrevQ  <= 1'b0;
         periodCntQ <= '0;
         periodQ    <= '0;
         riseSeenQ  <= 1'b0;
      end else begin
         segPrevQ  <= segS;
         halfPrevQ <= wheelS;
         if (segRise) begin
            periodQ    <= periodCntQ + 1'b1;
            periodCntQ <= '0;
            riseSeenQ  <= 1'b1;
         end else if (perOvf) begin
            riseSeenQ  <= 1'b0;
         end else begin
            periodCntQ <= periodCntQ + 1'b1;
         end
      end
   end

   // Lock: two segment rises give a period; a stopped wheel drops lock
   always_comb begin
      stateD = stateQ;
      case (stateQ)
         CGS_ACQ:  if (segRise && riseSeenQ) stateD = CGS_LOCK;
         CGS_LOCK: if (perOvf) stateD = CGS_ACQ;
         default:  stateD = CGS_ACQ;
      endcase
   end

   // Ten ticks per segment period, restarted on each segment rise
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stateQ   <= CGS_ACQ;
         tickCntQ <= '0;
         phaseQ   <= CGS_PHASE_RST;
      end else begin
         stateQ <= stateD;
         if (segRise) begin
            tickCntQ <= '0;
            phaseQ   <= CGS_PHASE_RST;
         end else if (tick) begin
            tickCntQ <= '0;
            if (phaseQ != CGS_PHASE_LAST) phaseQ <= phaseQ + 1'b1;
         end else begin
            tickCntQ <= tickCntQ + 1'b1;
         end
      end
   end

   // Gate decode from wheel half, segment level and centre window
   always_comb begin
      gatesD          = CGS_GATES_RST;
      gatesD.meas      = locked & wheelS & segS & inHi;
      gatesD.measDark  = locked & wheelS & ~segS & inLo;
      gatesD.reference = locked & ~wheelS & segS & inHi;
      gatesD.refDark   = locked & ~wheelS & ~segS & inLo;
   end

   // Switch controls; the test waveform enters through the dark switch
   always_comb begin
      switchD                = CGS_SWITCH_RST;
      switchD.darkSwitchOpen = darkCalS | elecTestS;
      switchD.testGenEn      = elecTestS;
      switchD.testWave       = elecTestS & (switches.testWave ^ testWrap);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gates     <= CGS_GATES_RST;
         switches  <= CGS_SWITCH_RST;
         pllLocked <= 1'b0;
         testCntQ  <= '0;
      end else begin
         gates     <= gatesD;
         switches  <= switchD;
         pllLocked <= locked;
         testCntQ  <= (elecTestS && !testWrap) ? testCntQ + 1'b1 : '0;
      end
   end

   // Indicators toggle every so many sensor edges; stuck when wheel stops
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         halfLedCntQ  <= '0;
         segLedCntQ   <= '0;
         wheelHalfLed <= 1'b0;
         segmentLed   <= 1'b0;
      end else begin
         if (halfEdge) begin
            halfLedCntQ <= ledNext(halfLedCntQ, HALF_LED_DIV);
            if (ledNext(halfLedCntQ, HALF_LED_DIV) == '0)
               wheelHalfLed <= ~wheelHalfLed;
         end
         if (segRise) begin
            segLedCntQ <= ledNext(segLedCntQ, SEG_LED_DIV);
            if (ledNext(segLedCntQ, SEG_LED_DIV) == '0)
               segmentLed <= ~segmentLed;
         end
      end
   end

   a_meas_gate_cause: assert property (
      @(posedge clk) disable iff (sys_rst)
      gates.meas |-> $past(wheelS && segS && locked))
      else $error("measure gate outside measure half or segment high");

   a_mdark_gate_cause: assert property (
      @(posedge clk) disable iff (sys_rst)
      gates.measDark |-> $past(wheelS && !segS && locked))
      else $error("measure dark gate outside measure half or segment low");

   a_ref_gates_cause: assert property (
      @(posedge clk) disable iff (sys_rst)
      (gates.reference || gates.refDark) |-> $past(!wheelS && locked)
      && (gates.reference == $past(segS)))
      else $error("reference gate decoded from the wrong half or level");

   a_gates_exclusive: assert property (
      @(posedge clk) disable iff (sys_rst)
      $onehot0(gates))
      else $error("more than one sample gate active");

   a_tick_phase_ref: assert property (
      @(posedge clk) disable iff (sys_rst)
      segRise |=> phaseQ == CGS_PHASE_RST && tickCntQ == '0)
      else $error("tick phase not restarted by segment rise");

   a_gate_centre: assert property (
      @(posedge clk) disable iff (sys_rst)
      (gates.meas || gates.reference) |-> $past(phaseQ) >= CGS_HI_FIRST
      && $past(phaseQ) <= CGS_HI_LAST)
      else $error("bright gate open outside the pulse centre");

   a_led_toggle_cause: assert property (
      @(posedge clk) disable iff (sys_rst)
      $changed(segmentLed) |-> $past(segRise))
      else $error("segment indicator toggled without a segment edge");

   a_dark_switch: assert property (
      @(posedge clk) disable iff (sys_rst)
      darkCalS |=> switches.darkSwitchOpen)
      else $error("dark calibration did not open the detector switch");

   a_test_route: assert property (
      @(posedge clk) disable iff (sys_rst)
      elecTestS ##1 elecTestS |-> switches.testGenEn
      && switches.darkSwitchOpen)
      else $error("electrical test not routed through the dark switch");

   a_sync_depth: assert property (
      @(posedge clk) disable iff (sys_rst)
      segRise |-> $past(segmentPin, 2) && !$past(segmentPin, 3))
      else $error("segment edge seen without two synchroniser stages");

endmodule

//--- cgs_wheel_model.sv
// Wheel sensor model: half-revolution level and segment pulse train.
// Assumes clk is the system clock; pins change 1 ns after its rising edge.
`timescale 1ns/1ps
module cgs_wheel_model #(
   parameter int PERIOD = 40
) (
   // Clock and control
   input  wire logic clk,
   input  wire logic run,
   input  int        segPerHalf,
   // Sensor pins
   output logic      wheelHalfPin,
   output logic      segmentPin,
   // Position seen by the bench
   output int        phaseCnt,
   output int        segCnt
);
   initial begin
      wheelHalfPin = 1'b0;
      segmentPin = 1'b0;
      phaseCnt = PERIOD - 1;
      segCnt = 0;
   end
   // A stopped wheel leaves both sensors at their last level
   always @(posedge clk) begin
      if (run) begin
         #1;
         phaseCnt = (phaseCnt + 1) % PERIOD;
         segmentPin = (phaseCnt < PERIOD / 2);
         if (phaseCnt == 0) begin
            segCnt = segCnt + 1;
            if (segCnt % segPerHalf == 0)
               wheelHalfPin = ~wheelHalfPin;
         end
      end
   end
endmodule

//--- test_chopper_gate_sequencer.sv
// Self-checking bench for the chopper gate sequencer.
// Assumes the wheel model drives the sensors; requests come from the bench.
`timescale 1ns/1ps
module test_chopper_gate_sequencer;
   import cgs_pkg::*;
   localparam int PER = 40;
   logic        clk, sys_rst, darkCalReq, elecTestReq, run, checkOn;
   logic        wheelHalfPin, segmentPin, wheelHalfLed, segmentLed;
   logic        pllLocked, h, hi;
   logic [1:0]  r;
   cgs_gates_t  gates;
   cgs_switch_t switches;
   int          failCount, checked, phaseCnt, segCnt, segPerHalf, k, i, s;

   cgs_chopper_gate_seq #(.TEST_HALF_CYC(10), .HALF_LED_DIV(2),
      .SEG_LED_DIV(2)) cgs_chopper_gate_seq_inst (
      .clk(clk), .sys_rst(sys_rst), .wheelHalfPin(wheelHalfPin),
      .segmentPin(segmentPin), .darkCalReq(darkCalReq),
      .elecTestReq(elecTestReq), .gates(gates), .switches(switches),
      .wheelHalfLed(wheelHalfLed), .segmentLed(segmentLed),
      .pllLocked(pllLocked));

   cgs_wheel_model #(.PERIOD(PER)) cgs_wheel_model_inst (
      .clk(clk), .run(run), .segPerHalf(segPerHalf),
      .wheelHalfPin(wheelHalfPin), .segmentPin(segmentPin),
      .phaseCnt(phaseCnt), .segCnt(segCnt));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      checked++;
      if (seen !== exp) begin
         failCount++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Reference model: centre windows of each segment period, LED counts
   always @(posedge clk) begin
      #2;
      if (checkOn && segCnt >= 3) begin
         k = phaseCnt;
         hi = (k < PER / 2);
         h = wheelHalfPin;
         if ((k >= 10 && k <= 17) || (k >= 30 && k <= 37))
            check(gates, {h&hi, h&~hi, ~h&hi, ~h&~hi});
         else if (k <= 5 || (k >= 21 && k <= 25))
            check(gates, 4'h0);
         if (k == 20) begin
            check({3'h0, pllLocked}, 4'h1);
            check(4'(wheelHalfLed), 4'(segCnt / segPerHalf / 2 % 2));
            check({3'h0, segmentLed}, 4'((segCnt / 2) % 2));
         end
      end
   end

   initial begin
      #100000;
      failCount++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      sys_rst = 1'b1;
      darkCalReq = 1'b0;
      elecTestReq = 1'b0;
      run = 1'b0;
      checkOn = 1'b0;
      failCount = 0;
      checked = 0;
      void'($urandom(32'h56f94f07));
      segPerHalf = $urandom_range(2, 3);
      repeat (10) @(posedge clk);
      #1 sys_rst = 1'b0;
      repeat (30) @(posedge clk);
      #2;
      check(gates, 4'h0);
      check({1'b0, switches}, 4'h0);
      check({1'b0, pllLocked, wheelHalfLed, segmentLed}, 4'h0);
      run = 1'b1;
      checkOn = 1'b1;
      s = $urandom_range(0, 3);
      // Every request combination, each from an idle start
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         darkCalReq = 1'b0;
         elecTestReq = 1'b0;
         repeat (4) @(posedge clk);
         #1;
         r = 2'(i + s);
         darkCalReq = r[0];
         elecTestReq = r[1];
         repeat (3) @(posedge clk);
         #2;
         check({1'b0, switches}, {1'b0, |r, r[1], 1'b0});
         repeat (5) @(posedge clk);
         #2;
         check({3'h0, switches.testWave}, 4'h0);
         repeat (10) @(posedge clk);
         #2;
         check({3'h0, switches.testWave}, {3'h0, r[1]});
      end
      wait (segCnt >= 14);
      checkOn = 1'b0;
      report_and_stop();
   end
endmodule
